// *** verilog/smp_port_ctrl.sv ***
// Purpose: Control of the external memory port for programmable synchronous and SDRAM accesses.
// Assumes: The selected output clock is fed back and sampled here; one access at a time.
// Notes:   Pins change one system clock after the sampled port clock rising edge.
`timescale 1ns/1ns
module smp_port_ctrl (
  input  wire logic                      SYS_CLK,                  // System clock, 50 MHz.
  input  wire logic                      RSTN,                     // Asynchronous reset, low.
  input  wire logic [1:0]                SYNC_READ_LATENCY,        // Sync read latency ticks.
  input  wire logic [1:0]                SYNC_WRITE_LATENCY,       // Sync write latency ticks.
  input  wire logic                      CHIP_SELECT_EXTEND,       // Hold select with OE.
  input  wire logic                      STROBE_FUNCTION_SELECT,   // 1 = FIFO read enable.
  input  wire logic                      SYNC_CLOCK_SELECT,        // 0 = clock one, 1 = two.
  input  wire logic [1:0]                DIRECT_READ_LATENCY,      // Direct strobe read delay.
  input  wire logic [1:0]                DIRECT_WRITE_LATENCY,     // Direct strobe write delay.
  input  wire logic                      PORT_CLOCK_OUT_ONE,       // Output clock one, sampled.
  input  wire logic                      PORT_CLOCK_OUT_TWO,       // Output clock two, sampled.
  input  wire logic                      REQ_VALID,                // Access request.
  input  wire logic                      REQ_WRITE,                // 1 = write access.
  input  wire logic                      REQ_SDRAM,                // 1 = SDRAM access.
  input  wire logic                      REQ_DIRECT,               // 1 = direct transfer.
  input  wire logic [smp_pkg::ADDR_W-1:0] REQ_ADDR,                // Access address.
  input  wire logic [smp_pkg::DATA_W-1:0] REQ_WDATA,               // Write data.
  output logic                           REQ_READY,                // High while idle with no request; drops once taken.
  output logic                           RD_VALID,                 // Read data pulse.
  output logic [smp_pkg::DATA_W-1:0]     RD_DATA,                  // Captured read data.
  output logic                           SPACE_CHIP_SELECT_N,      // Chip select pin.
  output logic                           SHARED_STROBE_ONE_N,      // Addr/read or column.
  output logic                           SHARED_STROBE_TWO_N,      // Output enable or row.
  output logic                           SHARED_STROBE_THREE_N,    // Write enable pin.
  output logic [smp_pkg::ADDR_W-1:0]     MEM_ADDR,                 // Address pins.
  output logic [smp_pkg::DATA_W-1:0]     DATA_OUT,                 // Data bus output.
  output logic                           DATA_OE,                  // Data bus drive enable.
  input  wire logic [smp_pkg::DATA_W-1:0] DATA_IN,                 // Data bus input pins.
  output logic                           DIRECT_TRANSFER_STROBE    // Direct transfer strobe.
);

  smp_pkg::smp_state_t         state_reg;
  logic [1:0]                  clk_s1_reg, clk_s2_reg, clk_s3_reg, clk_lvl_reg;
  logic [1:0]                  clk_lvl_next;
  logic                        tick;
  logic [smp_pkg::DATA_W-1:0]  din_s1_reg, din_s2_reg, din_s3_reg, din_reg;
  logic                        wr_reg, sdram_reg, dir_reg, ext_reg, fsel_reg;
  logic [1:0]                  lat_reg, dl_reg, cnt_reg;
  logic [smp_pkg::ADDR_W-1:0]  addr_reg;
  logic [smp_pkg::DATA_W-1:0]  wdata_reg;
  logic [smp_pkg::HIST_W-1:0]  hist_reg;
  logic                        data_phase, dp_direct, strobe_next;
  logic                        cs_next, one_next, two_next, three_next;
  logic                        addr_or_fifo_read_strobe, sync_output_enable, sync_write_enable;
  logic                        sdram_column_strobe, sdram_row_strobe, sdram_write_enable;

  // Port clocks and data bus come from outside, so each passes three flops.
  assign clk_lvl_next = (clk_s2_reg & clk_s3_reg) | (clk_lvl_reg & (clk_s2_reg ^ clk_s3_reg));
  assign tick = SYNC_CLOCK_SELECT ? (clk_lvl_next[1] & ~clk_lvl_reg[1])
                                  : (clk_lvl_next[0] & ~clk_lvl_reg[0]);

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      clk_s1_reg  <= smp_pkg::CLK_RESET;
      clk_s2_reg  <= smp_pkg::CLK_RESET;
      clk_s3_reg  <= smp_pkg::CLK_RESET;
      clk_lvl_reg <= smp_pkg::CLK_RESET;
      din_s1_reg  <= smp_pkg::DATA_RESET;
      din_s2_reg  <= smp_pkg::DATA_RESET;
      din_s3_reg  <= smp_pkg::DATA_RESET;
      din_reg     <= smp_pkg::DATA_RESET;
    end else begin
      clk_s1_reg  <= {PORT_CLOCK_OUT_TWO, PORT_CLOCK_OUT_ONE};
      clk_s2_reg  <= clk_s1_reg;
      clk_s3_reg  <= clk_s2_reg;
      clk_lvl_reg <= clk_lvl_next;
      din_s1_reg  <= DATA_IN;
      din_s2_reg  <= din_s1_reg;
      din_s3_reg  <= din_s2_reg;
      din_reg     <= (din_s2_reg & din_s3_reg) | (din_reg & (din_s2_reg ^ din_s3_reg));
    end
  end

  // The slot in which the data phase falls; latency counted in ticks from the command.
  assign data_phase = (state_reg == smp_pkg::SMP_CMD || state_reg == smp_pkg::SMP_WAIT)
                      && cnt_reg == smp_pkg::LAT_ZERO;
  assign dp_direct  = data_phase & dir_reg;

  // Access sequencer; request fields are latched when taken.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= smp_pkg::SMP_IDLE;
      wr_reg    <= 1'b0;
      sdram_reg <= 1'b0;
      dir_reg   <= 1'b0;
      ext_reg   <= 1'b0;
      fsel_reg  <= 1'b0;
      lat_reg   <= smp_pkg::LAT_ZERO;
      dl_reg    <= smp_pkg::LAT_ZERO;
      cnt_reg   <= smp_pkg::LAT_ZERO;
      addr_reg  <= smp_pkg::ADDR_RESET;
      wdata_reg <= smp_pkg::DATA_RESET;
    end else begin
      unique case (state_reg)
        smp_pkg::SMP_IDLE: begin
          if (REQ_VALID) begin
            state_reg <= smp_pkg::SMP_ARM;
            wr_reg    <= REQ_WRITE;
            sdram_reg <= REQ_SDRAM;
            dir_reg   <= REQ_DIRECT;
            ext_reg   <= CHIP_SELECT_EXTEND;
            fsel_reg  <= STROBE_FUNCTION_SELECT;
            addr_reg  <= REQ_ADDR;
            wdata_reg <= REQ_WDATA;
            dl_reg    <= REQ_WRITE ? DIRECT_WRITE_LATENCY : DIRECT_READ_LATENCY;
            if (REQ_SDRAM) begin
              lat_reg <= REQ_WRITE ? smp_pkg::LAT_ZERO : smp_pkg::SDRAM_CAS_LAT;
            end else begin
              lat_reg <= REQ_WRITE ? SYNC_WRITE_LATENCY : SYNC_READ_LATENCY;
            end
          end
        end
        smp_pkg::SMP_ARM: begin
          if (tick) begin
            state_reg <= smp_pkg::SMP_CMD;
            cnt_reg   <= lat_reg;
          end
        end
        smp_pkg::SMP_CMD, smp_pkg::SMP_WAIT: begin
          if (tick) begin
            if (data_phase) begin
              state_reg <= (!sdram_reg && !fsel_reg) ? smp_pkg::SMP_DESEL
                                                     : smp_pkg::SMP_FIN;
            end else begin
              state_reg <= smp_pkg::SMP_WAIT;
              cnt_reg   <= cnt_reg - 2'h1;
            end
          end
        end
        smp_pkg::SMP_DESEL: begin
          if (tick) begin
            state_reg <= smp_pkg::SMP_FIN;
          end
        end
        smp_pkg::SMP_FIN: begin
          // Waits until a delayed direct strobe has been issued.
          if (hist_reg == smp_pkg::HIST_RESET && !strobe_next) begin
            state_reg <= smp_pkg::SMP_IDLE;
          end
        end
      endcase
    end
  end

  // Pin roles per state, then the shared pins chosen by access type.
  always_comb begin
    cs_next                  = 1'b0;
    addr_or_fifo_read_strobe = 1'b0;
    sync_output_enable       = 1'b0;
    sync_write_enable        = 1'b0;
    sdram_column_strobe      = 1'b0;
    sdram_row_strobe         = 1'b0;
    sdram_write_enable       = 1'b0;
    unique case (state_reg)
      smp_pkg::SMP_CMD: begin
        cs_next                  = 1'b1;
        addr_or_fifo_read_strobe = !wr_reg || !fsel_reg;
        sync_output_enable       = !wr_reg;
        sync_write_enable        = wr_reg;
        sdram_column_strobe      = 1'b1;
        sdram_write_enable       = wr_reg;
      end
      smp_pkg::SMP_WAIT: begin
        sync_output_enable = !wr_reg;
        cs_next            = ext_reg && !wr_reg && !sdram_reg;
      end
      smp_pkg::SMP_DESEL: begin
        addr_or_fifo_read_strobe = 1'b1;
      end
      default: begin
      end
    endcase
    one_next   = sdram_reg ? sdram_column_strobe : addr_or_fifo_read_strobe;
    two_next   = sdram_reg ? sdram_row_strobe : sync_output_enable;
    three_next = sdram_reg ? sdram_write_enable : sync_write_enable;
  end

  // Direct strobe delay line in ticks, tapped by the latched latency field.
  assign strobe_next = (dl_reg == smp_pkg::LAT_ZERO) ? dp_direct : hist_reg[dl_reg - 2'h1];

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      hist_reg <= smp_pkg::HIST_RESET;
    end else if (tick) begin
      hist_reg <= {hist_reg[1:0], dp_direct};
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      DIRECT_TRANSFER_STROBE <= 1'b0;
    end else begin
      DIRECT_TRANSFER_STROBE <= strobe_next;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      SPACE_CHIP_SELECT_N   <= smp_pkg::PIN_IDLE_N;
      SHARED_STROBE_ONE_N   <= smp_pkg::PIN_IDLE_N;
      SHARED_STROBE_TWO_N   <= smp_pkg::PIN_IDLE_N;
      SHARED_STROBE_THREE_N <= smp_pkg::PIN_IDLE_N;
      MEM_ADDR              <= smp_pkg::ADDR_RESET;
      DATA_OUT              <= smp_pkg::DATA_RESET;
      DATA_OE               <= 1'b0;
    end else begin
      SPACE_CHIP_SELECT_N   <= !cs_next;
      SHARED_STROBE_ONE_N   <= !one_next;
      SHARED_STROBE_TWO_N   <= !two_next;
      SHARED_STROBE_THREE_N <= !three_next;
      MEM_ADDR              <= addr_reg;
      DATA_OUT              <= wdata_reg;
      DATA_OE               <= data_phase && wr_reg && !dir_reg;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      REQ_READY <= 1'b0;
      RD_VALID  <= 1'b0;
      RD_DATA   <= smp_pkg::DATA_RESET;
    end else begin
      REQ_READY <= (state_reg == smp_pkg::SMP_IDLE) && !REQ_VALID;
      RD_VALID  <= tick && data_phase && !wr_reg && !dir_reg;
      if (tick && data_phase && !wr_reg && !dir_reg) begin
        RD_DATA <= din_reg;
      end
    end
  end

  // Helper for the checks: ticks since the command slot began.
  logic [smp_pkg::TCNT_W-1:0] tcnt_reg;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tcnt_reg <= smp_pkg::TCNT_RESET;
    end else if (state_reg == smp_pkg::SMP_ARM) begin
      tcnt_reg <= smp_pkg::TCNT_RESET;
    end else if (tick && tcnt_reg != smp_pkg::TCNT_MAX) begin
      tcnt_reg <= tcnt_reg + 3'h1;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  a_latency_count: assert property (data_phase |-> tcnt_reg == {1'b0, lat_reg})
    else $error("data phase not at programmed latency");
  a_cs_release: assert property (state_reg == smp_pkg::SMP_WAIT && !ext_reg |=> SPACE_CHIP_SELECT_N)
    else $error("chip select held after command");
  a_cs_extend: assert property (state_reg == smp_pkg::SMP_WAIT && ext_reg && !wr_reg && !sdram_reg
                                |=> !SPACE_CHIP_SELECT_N && !SHARED_STROBE_TWO_N)
    else $error("chip select not held with output enable");
  a_desel_insert: assert property (tick && data_phase && !sdram_reg && !fsel_reg
                                   |=> state_reg == smp_pkg::SMP_DESEL)
    else $error("deselect tick missing");
  a_no_desel: assert property (fsel_reg |-> state_reg != smp_pkg::SMP_DESEL)
    else $error("deselect tick in read enable mode");
  a_tick_source: assert property (tick |-> (SYNC_CLOCK_SELECT ? clk_lvl_next[1] : clk_lvl_next[0]))
    else $error("tick from unselected clock");
  a_sync_roles: assert property (state_reg == smp_pkg::SMP_CMD && !sdram_reg && !wr_reg
                                 |=> !SHARED_STROBE_ONE_N && !SHARED_STROBE_TWO_N
                                     && SHARED_STROBE_THREE_N)
    else $error("sync read command pins wrong");
  a_sdram_roles: assert property (state_reg == smp_pkg::SMP_CMD && sdram_reg && wr_reg
                                  |=> !SHARED_STROBE_ONE_N && SHARED_STROBE_TWO_N
                                      && !SHARED_STROBE_THREE_N)
    else $error("sdram write command pins wrong");
  a_direct_only: assert property (DIRECT_TRANSFER_STROBE |-> $past(dir_reg))
    else $error("direct strobe on plain transfer");
  a_no_capture: assert property (tick && data_phase && dir_reg |=> !RD_VALID)
    else $error("direct read data captured");
  a_direct_delay: assert property ($rose(DIRECT_TRANSFER_STROBE)
                                   |-> $past(tcnt_reg) == 3'({1'b0, lat_reg} + {1'b0, dl_reg}))
    else $error("direct strobe delay wrong");
  a_write_hiz: assert property (DATA_OE |-> !$past(dir_reg) && $past(wr_reg))
    else $error("data bus driven on direct write");

  c_read_lat3: cover property (RD_VALID && lat_reg == 2'h3);
  c_direct_read: cover property ($rose(DIRECT_TRANSFER_STROBE) && !wr_reg && dl_reg == 2'h2);
  c_deselect: cover property (state_reg == smp_pkg::SMP_DESEL);
  c_sdram_write: cover property (DATA_OE && sdram_reg);

endmodule

// *** inc/smp_pkg.sv ***
// Purpose: Shared constants and types of the synchronous memory port control block.
// Assumes: Narrow port widths, active-low control pins, latencies counted in port clock ticks.
// Notes:   Used by verilog/smp_port_ctrl.sv through scoped names only.
package smp_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned LAT_W  = 2;
  localparam int unsigned HIST_W = 3;
  localparam int unsigned TCNT_W = 3;

  // Fixed column latency used for SDRAM read data phases, in port clock ticks.
  localparam logic [LAT_W-1:0] SDRAM_CAS_LAT = 2'h3;
  localparam logic [LAT_W-1:0] LAT_ZERO      = 2'h0;

  // Reset values of the pins, the read result and the internal registers, and the tick counter limit.
  localparam logic              PIN_IDLE_N  = 1'b1;
  localparam logic [DATA_W-1:0] DATA_RESET  = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET  = 20'h00000;
  localparam logic [HIST_W-1:0] HIST_RESET  = 3'h0;
  localparam logic [TCNT_W-1:0] TCNT_RESET  = 3'h0;
  localparam logic [TCNT_W-1:0] TCNT_MAX    = 3'h7;
  localparam logic [1:0]        CLK_RESET   = 2'h0;

  // Access sequencer states; CMD and DESEL last one port clock tick, WAIT one tick per latency tick.
  typedef enum logic [2:0] {
    SMP_IDLE,
    SMP_ARM,
    SMP_CMD,
    SMP_WAIT,
    SMP_DESEL,
    SMP_FIN
  } smp_state_t;

endpackage

// *** verification/smp_mem_model.sv ***
// Purpose: Behavioural synchronous memory on the far side of the port.
// Assumes: Clocked by the selected port clock; sixteen words decoded from the low address.
// Notes:   Outside a read window the data pins show a pattern that flips every cycle.
`timescale 1ns/1ns
module smp_mem_model (
  input  wire logic                       port_clk,  // Selected port clock.
  input  wire logic                       sys_clk,   // System clock, paces the idle pattern.
  input  wire logic                       cs_n,      // Chip select.
  input  wire logic                       one_n,     // Address strobe or column strobe.
  input  wire logic                       three_n,   // Write enable.
  input  wire logic [smp_pkg::ADDR_W-1:0] addr,      // Address pins.
  input  wire logic                       data_oe,   // Port drives the data bus.
  input  wire logic [smp_pkg::DATA_W-1:0] data_wr,   // Data from the port.
  output logic      [smp_pkg::DATA_W-1:0] data_rd    // Data to the port.
);
  logic [smp_pkg::DATA_W-1:0] mem_reg [16];
  logic [2:0]                 win_reg;
  logic [smp_pkg::DATA_W-1:0] idle_reg;
  logic                       rd_cmd;
  initial begin
    for (int i = 0; i < 16; i++) mem_reg[i] = 16'h5a00 ^ i[15:0];
    win_reg = 3'h0;
    idle_reg = 16'h0f0f;
  end
  assign rd_cmd = !cs_n && !one_n && three_n;
  // A read command opens a window long enough for the slowest data phase.
  always @(posedge port_clk) begin
    if (rd_cmd) win_reg <= 3'h5;
    else if (win_reg != 3'h0) win_reg <= win_reg - 3'h1;
    if (data_oe) mem_reg[addr[3:0]] <= data_wr;
  end
  always @(posedge sys_clk) idle_reg <= ~idle_reg;
  assign data_rd = (rd_cmd || win_reg != 3'h0) ? mem_reg[addr[3:0]] : idle_reg;
endmodule

// *** verification/smp_port_ctrl_tb.sv ***
// Purpose: Self-checking bench of the synchronous memory port control block.
// Assumes: Both port clocks are made here and run free; a memory model answers.
// Notes:   Pin timing is measured in rising edges of the selected port clock.
`timescale 1ns/1ns
module smp_port_ctrl_tb;
  logic        sys_clk, rstn, clk_one, clk_two, req_valid, req_write, req_sdram, req_direct;
  logic        ext, fsel, csel, ready, rd_valid, cs_n, one_n, two_n, three_n, data_oe, strobe;
  logic [1:0]  rl, wl, drl, dwl;
  logic [smp_pkg::ADDR_W-1:0] addr, mem_addr;
  logic [smp_pkg::DATA_W-1:0] wdata, rd_data, data_out, data_in;
  logic [smp_pkg::DATA_W-1:0] exp_mem [16];
  int          seed, fails, cmp_count, cycles, t1, t2, tick, cmd_t, oe_t, st_t, rv_t;
  logic        busy, f_gap, f_desel, f_oe, f_we, f_rv;
  logic [31:0] k;

  smp_port_ctrl DUT (.SYS_CLK(sys_clk), .RSTN(rstn), .SYNC_READ_LATENCY(rl),
    .SYNC_WRITE_LATENCY(wl), .CHIP_SELECT_EXTEND(ext), .STROBE_FUNCTION_SELECT(fsel),
    .SYNC_CLOCK_SELECT(csel), .DIRECT_READ_LATENCY(drl), .DIRECT_WRITE_LATENCY(dwl),
    .PORT_CLOCK_OUT_ONE(clk_one), .PORT_CLOCK_OUT_TWO(clk_two), .REQ_VALID(req_valid),
    .REQ_WRITE(req_write), .REQ_SDRAM(req_sdram), .REQ_DIRECT(req_direct), .REQ_ADDR(addr),
    .REQ_WDATA(wdata), .REQ_READY(ready), .RD_VALID(rd_valid), .RD_DATA(rd_data),
    .SPACE_CHIP_SELECT_N(cs_n), .SHARED_STROBE_ONE_N(one_n), .SHARED_STROBE_TWO_N(two_n),
    .SHARED_STROBE_THREE_N(three_n), .MEM_ADDR(mem_addr), .DATA_OUT(data_out),
    .DATA_OE(data_oe), .DATA_IN(data_in), .DIRECT_TRANSFER_STROBE(strobe));

  smp_mem_model mem (.port_clk(csel ? clk_two : clk_one), .sys_clk(sys_clk), .cs_n(cs_n),
    .one_n(one_n), .three_n(three_n), .addr(mem_addr), .data_oe(data_oe),
    .data_wr(data_out), .data_rd(data_in));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Port clocks differ in rate and phase so a wrong clock select shows in the tick counts.
  initial begin
    clk_one = 1'b0;
    #7;
    forever #80 clk_one = ~clk_one;
  end
  initial begin
    clk_two = 1'b0;
    #33;
    forever #120 clk_two = ~clk_two;
  end
  always @(posedge clk_one) t1++;
  always @(posedge clk_two) t2++;
  assign tick = csel ? t2 : t1;

  task automatic summarize();
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check_ticks(input int got, input int want, input string what);
    cmp_count++;
    if (got != want) begin
      fails++;
      $display("MISMATCH %0t %s got %0d want %0d", $time, what, got, want);
    end
  endtask

  task automatic check_flag(input logic got, input logic want, input string what);
    cmp_count++;
    if (got !== want) begin
      fails++;
      $display("MISMATCH %0t %s got %b want %b", $time, what, got, want);
    end
  endtask

  task automatic check_data(input logic [15:0] got, input logic [15:0] want);
    cmp_count++;
    if (got !== want) begin
      fails++;
      $display("MISMATCH %0t read data got %h want %h", $time, got, want);
    end
  endtask

  // Watches the pins during one access and notes when and what they did.
  // Sampling on the falling edge keeps clear of the edge that updates the pins.
  always @(negedge sys_clk) begin
    cycles++;
    if (cycles > 60000) begin
      fails++;
      summarize();
    end
    if (busy) begin
      if (cmd_t < 0 && !cs_n && !(one_n && three_n)) cmd_t = tick;
      if (oe_t < 0 && data_oe) oe_t = tick;
      if (st_t < 0 && strobe) st_t = tick;
      if (rd_valid) rv_t = tick;
      if (rd_valid) f_rv = 1'b1;
      if (!two_n && cs_n) f_gap = 1'b1;
      if (cs_n && !one_n) f_desel = 1'b1;
      if (!two_n) f_oe = 1'b1;
      if (!three_n) f_we = 1'b1;
    end
  end

  task automatic access(input logic [31:0] c);
    logic [smp_pkg::ADDR_W-1:0] a;
    logic [smp_pkg::DATA_W-1:0] d;
    int lat;
    int dl;
    a = $random(seed);
    d = $random(seed);
    @(posedge sys_clk);
    csel <= c[5];
    {dwl, drl, wl, rl} <= c[13:6];
    {fsel, ext, req_direct, req_sdram, req_write} <= c[4:0];
    addr <= a;
    wdata <= d;
    cmd_t = -1;
    oe_t = -1;
    st_t = -1;
    rv_t = -1;
    {f_gap, f_desel, f_oe, f_we, f_rv} = 5'h00;
    busy = 1'b1;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    for (int n = 0; n < 50 && ready !== 1'b0; n++) @(posedge sys_clk);
    req_valid <= 1'b0;
    for (int n = 0; n < 600 && ready !== 1'b1; n++) @(posedge sys_clk);
    busy = 1'b0;
    lat = c[1] ? (c[0] ? 0 : 3) : (c[0] ? int'(c[9:8]) : int'(c[7:6]));
    dl = c[0] ? int'(c[13:12]) : int'(c[11:10]);
    check_flag(cmd_t >= 0, 1'b1, "command seen");
    if (!c[0] && !c[2]) check_ticks(rv_t - cmd_t, lat + 1, "read phase");
    if (!c[0] && !c[2]) check_data(rd_data, exp_mem[a[3:0]]);
    if (c[0] && !c[2]) check_ticks(oe_t - cmd_t, lat, "write phase");
    if (c[0] && !c[2]) exp_mem[a[3:0]] = d;
    check_ticks(st_t - cmd_t, c[2] ? lat + dl : -1 - cmd_t, "direct strobe");
    if (c[2] && !c[0]) check_flag(f_rv, 1'b0, "direct read capture");
    if (c[2] && c[0]) check_ticks(oe_t, -1, "direct write drive");
    check_flag(f_desel, !c[1] && !c[4], "deselect slot");
    check_flag(f_oe, !c[1] && !c[0], "output enable role");
    check_flag(f_we, c[0], "write enable role");
    if (!c[1] && !c[0] && !c[3] && c[7:6] != 2'b00) check_flag(f_gap, 1'b1, "select drop");
    if (!c[1] && !c[0] && c[3]) check_flag(f_gap, 1'b0, "select held");
  endtask

  initial begin
    seed = 32'h5237;
    {rstn, req_valid, req_write, req_sdram, req_direct, ext, fsel, csel} = 8'h00;
    {rl, wl, drl, dwl} = 8'h00;
    addr = '0;
    wdata = '0;
    {fails, cmp_count, cycles, t1, t2} = 160'h0;
    busy = 1'b0;
    for (int i = 0; i < 16; i++) exp_mem[i] = 16'h5a00 ^ i[15:0];
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    // The first sixteen accesses sweep every sync latency and clock select by hand, no SDRAM or direct; the rest are random.
    for (int i = 0; i < 64; i++) begin
      k = (i < 16) ? {i[1:0], i[1:0], i[2] ^ i[3], i[3], i[3], 2'b00, i[2]} : $random(seed);
      access(k);
    end
    summarize();
  end
endmodule
